// ### verilog/pcs_pkg.sv
// Notes on behaviour
// - the loop output frequency is its input divided by reference+1, times feedback+1, divided by output+1.
// - the loop input is the fast crystal oscillator or the external clock drive, per the reference source select.
// - the source field switches only after a delay, and reads return the source actually active.
// - source codes are 000 tuned oscillator, 001 peripheral, 010 crystal or external, 011 loop, 100 watchdog; 101-111 reserved.
package pcs_pkg;
    // register byte offsets
    localparam logic [11:0] PCS_OFF_CTRL = 12'h000;
    localparam logic [11:0] PCS_OFF_LOOP = 12'h004;
    localparam logic [11:0] PCS_OFF_STAT = 12'h008;
    localparam logic [11:0] PCS_OFF_FREQ = 12'h00C;
    // control register field positions
    localparam int PCS_CTRL_SRC_LSB = 0;
    localparam int PCS_CTRL_REF_BIT = 3;
    localparam int PCS_CTRL_DIV_LSB = 8;
    // loop register field positions
    localparam int PCS_LOOP_RDIV_LSB = 0;
    localparam int PCS_LOOP_NDIV_LSB = 8;
    localparam int PCS_LOOP_ODIV_LSB = 16;
    // status register field positions
    localparam int PCS_STAT_REQ_LSB = 0;
    localparam int PCS_STAT_PEND_BIT = 3;
    localparam int PCS_STAT_BUSY_BIT = 4;
    // reset values
    localparam logic [2:0] PCS_SRC_RESET = 3'h0;
    localparam logic [5:0] PCS_RDIV_RESET = 6'h00;
    localparam logic [6:0] PCS_NDIV_RESET = 7'h1F;
    localparam logic [3:0] PCS_ODIV_RESET = 4'h1;
    localparam logic [3:0] PCS_SDIV_RESET = 4'h0;
    // switch delay in ns and in pclk cycles (least time, rounded up)
    localparam int PCS_CLK_PERIOD_NS = 10;
    localparam int PCS_SWITCH_DELAY_NS = 100;
    localparam int PCS_SWITCH_CYCLES =
        (PCS_SWITCH_DELAY_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS;

    // system clock source codes
    typedef enum logic [2:0] {
        PCS_SRC_TUNED = 3'h0,
        PCS_SRC_PERIPH = 3'h1,
        PCS_SRC_XTAL = 3'h2,
        PCS_SRC_LOOP = 3'h3,
        PCS_SRC_WDOG = 3'h4
    } pcs_src_e;

    // switch sequencer, one-hot
    typedef enum logic [3:0] {
        PCS_ST_IDLE = 4'b0001,
        PCS_ST_DELAY = 4'b0010,
        PCS_ST_OLD_LOW = 4'b0100,
        PCS_ST_NEW_LOW = 4'b1000
    } pcs_state_e;

    // divider settings of the loop
    typedef struct packed {
        logic [5:0] loop_ref_divider;
        logic [6:0] loop_feedback_divider;
        logic [3:0] loop_output_divider;
    } pcs_loop_cfg_s;
endpackage

// ### verilog/pcs_divider.sv
`timescale 1ns/1ps
`default_nettype none
// serial restoring divider: one quotient bit per cycle
module pcs_divider
    import pcs_pkg::*;
#(
    parameter int NUM_W = 32,
    parameter int DEN_W = 16
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [NUM_W-1:0] numer,
    input wire logic [DEN_W-1:0] denom,
    output logic busy,
    output logic [NUM_W-1:0] quot
);
    // refused at elaboration: the 7-bit bit counter and the shifts need these bounds
    if (NUM_W < DEN_W || DEN_W < 2 || NUM_W > 64)
    begin
        $error("pcs_divider: unsupported widths");
    end

    logic [NUM_W-1:0] q_r;
    logic [DEN_W:0] rem_r;
    logic [DEN_W-1:0] den_r;
    logic [6:0] cnt_r;
    logic busy_r;
    logic [NUM_W-1:0] res_r;
    logic [DEN_W:0] shifted;
    logic take;

    // trial subtraction on the shifted remainder
    assign shifted = {rem_r[DEN_W-1:0], q_r[NUM_W-1]};
    assign take = (shifted >= {1'b0, den_r});

    // start is ignored while a division runs; a zero divisor cannot occur here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_r <= '0;
            rem_r <= '0;
            den_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            res_r <= '0;
        end
        else if (start && !busy_r)
        begin
            q_r <= numer;
            rem_r <= '0;
            den_r <= denom;
            cnt_r <= 7'(NUM_W);
            busy_r <= 1'b1;
        end
        else if (busy_r)
        begin
            rem_r <= take ? (shifted - {1'b0, den_r}) : shifted;
            q_r <= {q_r[NUM_W-2:0], take};
            cnt_r <= cnt_r - 7'h01;
            if (cnt_r == 7'h01)
            begin
                busy_r <= 1'b0;
                res_r <= {q_r[NUM_W-2:0], take};
            end
        end
    end

    assign busy = busy_r;
    assign quot = res_r;
endmodule
`default_nettype wire

// ### verilog/pcs_clock_select.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// system clock selection, loop divider settings and apb registers
module pcs_clock_select
    import pcs_pkg::*;
#(
    parameter int XTAL_KHZ = 3000,
    parameter int EXT_KHZ = 3000
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic digital_tuned_osc,
    input wire logic periph_clk,
    input wire logic fast_crystal_osc,
    input wire logic ext_clk_drive,
    input wire logic loop_clk,
    input wire logic watchdog_osc,
    output logic loop_input_clock,
    output logic sys_clk,
    output logic [2:0] active_source,
    output logic [3:0] sys_clk_divider,
    output logic [16:0] loop_cfg
);
    // refused at elaboration: kHz inputs must fit the 16-bit operand
    // and the switch delay must fit its 8-bit counter
    if (XTAL_KHZ < 1 || XTAL_KHZ > 65535 || EXT_KHZ < 1 || EXT_KHZ > 65535
        || PCS_SWITCH_CYCLES < 1 || PCS_SWITCH_CYCLES > 255)
    begin
        $error("pcs_clock_select: parameter out of range");
    end

    // level of a source by code; reserved codes give a quiet low
    function automatic logic src_level(input logic [2:0] code, input logic [4:0] lv);
        src_level = (code <= 3'h4) ? lv[code] : 1'b0;
    endfunction

    // reference frequencies in kHz, only used for the frequency readback
    localparam logic [15:0] XTAL_K = 16'(XTAL_KHZ);
    localparam logic [15:0] EXT_K = 16'(EXT_KHZ);

    // software settings and the source actually in use
    logic [2:0] active_r, req_r;
    logic ref_sel_r;
    logic [3:0] sdiv_r;
    pcs_loop_cfg_s cfg_r;

    // switch sequencer
    pcs_state_e state_r, state_nxt;
    logic [7:0] dly_r;

    // output levels and apb answer
    logic out_r, ref_out_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    // frequency readback; a shared serial divider saves a wide combinational one
    logic calc_start_r;
    logic calc_busy;
    logic [31:0] freq_khz;

    // apb decode; setup phase is answered in the following access cycle
    wire setup = psel && !penable;
    wire access = psel && penable && pready_r;
    wire hit_ctrl = (paddr == PCS_OFF_CTRL);
    wire hit_loop = (paddr == PCS_OFF_LOOP);
    wire hit_stat = (paddr == PCS_OFF_STAT);
    wire hit_freq = (paddr == PCS_OFF_FREQ);
    wire mapped = hit_ctrl || hit_loop || hit_stat || hit_freq;
    wire wr_ctrl = access && pwrite && hit_ctrl;
    wire wr_loop = access && pwrite && hit_loop;
    wire [2:0] wr_src = pwdata[PCS_CTRL_SRC_LSB +: 3];
    // reserved codes are dropped so the mux never parks on a dead source
    wire src_ok = (wr_src <= 3'(PCS_SRC_WDOG));
    wire pending = (state_r != PCS_ST_IDLE);

    // read mux; the source field shows the active source, not the request
    wire [31:0] rd_ctrl = (32'(sdiv_r) << PCS_CTRL_DIV_LSB)
        | (32'(ref_sel_r) << PCS_CTRL_REF_BIT) | (32'(active_r) << PCS_CTRL_SRC_LSB);
    wire [31:0] rd_loop = (32'(cfg_r.loop_output_divider) << PCS_LOOP_ODIV_LSB)
        | (32'(cfg_r.loop_feedback_divider) << PCS_LOOP_NDIV_LSB)
        | (32'(cfg_r.loop_ref_divider) << PCS_LOOP_RDIV_LSB);
    wire [31:0] rd_stat = (32'(calc_busy) << PCS_STAT_BUSY_BIT)
        | (32'(pending) << PCS_STAT_PEND_BIT) | (32'(req_r) << PCS_STAT_REQ_LSB);
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl : hit_loop ? rd_loop
        : hit_stat ? rd_stat : hit_freq ? freq_khz : 32'h0000_0000;

    // apb answer flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // software settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_r <= PCS_SRC_RESET;
            ref_sel_r <= 1'b0;
            sdiv_r <= PCS_SDIV_RESET;
            cfg_r <= '{PCS_RDIV_RESET, PCS_NDIV_RESET, PCS_ODIV_RESET};
            calc_start_r <= 1'b1;
        end
        else
        begin
            calc_start_r <= wr_loop || wr_ctrl;
            if (wr_ctrl)
            begin
                if (src_ok)
                    req_r <= wr_src;
                ref_sel_r <= pwdata[PCS_CTRL_REF_BIT];
                sdiv_r <= pwdata[PCS_CTRL_DIV_LSB +: 4];
            end
            if (wr_loop)
            begin
                cfg_r.loop_ref_divider <= pwdata[PCS_LOOP_RDIV_LSB +: 6];
                cfg_r.loop_feedback_divider <= pwdata[PCS_LOOP_NDIV_LSB +: 7];
                cfg_r.loop_output_divider <= pwdata[PCS_LOOP_ODIV_LSB +: 4];
            end
        end
    end

    wire ref_lvl = ref_sel_r ? ext_clk_drive : fast_crystal_osc;
    wire [4:0] lv = {watchdog_osc, loop_clk, ref_lvl, periph_clk, digital_tuned_osc};
    wire old_lvl = src_level(active_r, lv);
    wire new_lvl = src_level(req_r, lv);

    // switch sequencer: delay, then wait for both sources low before handover
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PCS_ST_IDLE: if (req_r != active_r) state_nxt = PCS_ST_DELAY;
            PCS_ST_DELAY: if (dly_r == 8'h01) state_nxt = PCS_ST_OLD_LOW;
            PCS_ST_OLD_LOW: if (!old_lvl) state_nxt = PCS_ST_NEW_LOW;
            PCS_ST_NEW_LOW: if (!new_lvl && !old_lvl) state_nxt = PCS_ST_IDLE;
            default: state_nxt = PCS_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= PCS_ST_IDLE;
            dly_r <= 8'h00;
            active_r <= PCS_SRC_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            dly_r <= (state_r == PCS_ST_IDLE) ? 8'(PCS_SWITCH_CYCLES) : dly_r - 8'h01;
            if (state_r == PCS_ST_NEW_LOW && state_nxt == PCS_ST_IDLE)
                active_r <= req_r;
        end
    end

    // old source runs on, output held low across the handover
    wire gate_low = (state_r == PCS_ST_NEW_LOW);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_r <= 1'b0;
            ref_out_r <= 1'b0;
        end
        else
        begin
            out_r <= gate_low ? 1'b0 : old_lvl;
            ref_out_r <= ref_lvl;
        end
    end

    // loop output in kHz: fin * (n+1) / ((r+1) * (o+1))
    wire [15:0] fin = ref_sel_r ? EXT_K : XTAL_K;
    wire [31:0] numer = 32'(fin) * 32'({1'b0, cfg_r.loop_feedback_divider} + 8'h01);
    wire [15:0] denom = 16'({1'b0, cfg_r.loop_ref_divider} + 7'h01)
        * 16'({1'b0, cfg_r.loop_output_divider} + 5'h01);
    // the result lags a settings write by the division time; a write during a running division starts none and is not recomputed; status shows busy
    pcs_divider #(.NUM_W(32), .DEN_W(16)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(calc_start_r),
        .numer(numer),
        .denom(denom),
        .busy(calc_busy),
        .quot(freq_khz)
    );

    // every output is a flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sys_clk = out_r;
    assign loop_input_clock = ref_out_r;
    assign active_source = active_r;
    assign sys_clk_divider = sdiv_r;
    assign loop_cfg = cfg_r;
endmodule
`default_nettype wire

// ### sim/pcs_clock_select_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches apb writes, the loop settings and the source handover at the pins
module pcs_clock_select_monitor
    import pcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic digital_tuned_osc,
    input wire logic periph_clk,
    input wire logic fast_crystal_osc,
    input wire logic ext_clk_drive,
    input wire logic loop_clk,
    input wire logic watchdog_osc,
    input wire logic loop_input_clock,
    input wire logic sys_clk,
    input wire logic [2:0] active_source,
    input wire logic [16:0] loop_cfg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] src_q;
    logic [2:0] req_q;
    // write decode; a request equal to the active source starts no switch
    wire acc = psel && penable && pwrite && pready;
    wire wr_loop = acc && paddr == PCS_OFF_LOOP;
    wire wr_new = acc && paddr == PCS_OFF_CTRL && pwdata[2:0] <= 3'h4
        && pwdata[2:0] != active_source;
    // outputs are registered, so compare against sources one cycle back
    always_ff @(posedge pclk)
    begin
        src_q <= {3'h0, watchdog_osc, loop_clk, fast_crystal_osc | ext_clk_drive,
            periph_clk, digital_tuned_osc};
        if (wr_new)
            req_q <= pwdata[2:0];
    end
    sequence old_holds;
        $stable(active_source) [*8];
    endsequence
    switch_delay_a: assert property (wr_new |=> old_holds ##[1:190] active_source == req_q)
        else $error("source switched early or never");
    src_code_a: assert property (active_source <= 3'h4)
        else $error("reserved source code active");
    clk_follow_a: assert property (sys_clk |-> src_q[active_source])
        else $error("sys_clk high while active source low");
    handover_low_a: assert property ($changed(active_source) |-> !$past(sys_clk))
        else $error("handover without low phase");
    ref_follow_a: assert property (loop_input_clock |-> src_q[2])
        else $error("loop input high with no reference high");
    loop_field_a: assert property (wr_loop |=> loop_cfg == {$past(pwdata[5:0]),
        $past(pwdata[14:8]), $past(pwdata[19:16])})
        else $error("loop settings not taken from write");
    loop_keep_a: assert property ($changed(loop_cfg) |-> $past(wr_loop))
        else $error("loop settings changed without write");
endmodule
bind pcs_clock_select pcs_clock_select_monitor i_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .digital_tuned_osc, .periph_clk, .fast_crystal_osc,
    .ext_clk_drive, .loop_clk, .watchdog_osc, .loop_input_clock, .sys_clk, .active_source,
    .loop_cfg);
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import pcs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic loop_input_clock, sys_clk;
    logic [2:0] active_source;
    logic [3:0] sys_clk_divider;
    logic [16:0] loop_cfg;
    logic [7:0] cnt = 8'h00;
    int n_mismatch = 0, n_tests = 0;
    // sys_clk rises in 64 edges per source code: counter bits 1, 2, 3, 0, 5
    int rises [5] = '{16, 8, 4, 32, 1};
    always #5 pclk = ~pclk;
    // source clocks at distinct rates, each a counter bit
    always @(posedge pclk)
        cnt <= cnt + 8'h01;
    pcs_clock_select #(.XTAL_KHZ(3000), .EXT_KHZ(4500)) i_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .digital_tuned_osc(cnt[1]), .periph_clk(cnt[2]), .fast_crystal_osc(cnt[3]),
        .ext_clk_drive(cnt[4]), .loop_clk(cnt[0]), .watchdog_osc(cnt[5]),
        .loop_input_clock, .sys_clk, .active_source, .sys_clk_divider, .loop_cfg);
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a used-up wait bound ends the run
    task automatic limit(input int k, input int n);
        if (k >= n)
        begin
            check("wait bound", 32'h0, 32'h1);
            test_done();
        end
    endtask
    // one apb transfer; an idle edge follows so the next setup never lands in this step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        limit(k, 20);
        rd = prdata;
        check("pslverr", {31'h0, e}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle_calc;
        int k;
        for (k = 0; k < 60; k++)
        begin
            apb(1'b0, PCS_OFF_STAT, 32'h0, 1'b0);
            if (rd[PCS_STAT_BUSY_BIT] === 1'b0)
                break;
        end
        limit(k, 60);
    endtask
    // rising levels of sys_clk (sel 1) or loop_input_clock (sel 0) over 64 edges
    task automatic count_rises(input logic sel, output int k);
        logic prev, cur;
        k = 0;
        prev = sel ? sys_clk : loop_input_clock;
        repeat (64)
        begin
            @(posedge pclk);
            cur = sel ? sys_clk : loop_input_clock;
            if (cur && !prev)
                k++;
            prev = cur;
        end
    endtask
    task automatic t_reset;
        apb(1'b0, PCS_OFF_LOOP, 32'h0, 1'b0);
        check("loop reg", 32'h0001_1F00, rd);
        check("loop_cfg", 32'h0000_01F1, {15'h0, loop_cfg});
        apb(1'b0, 12'h010, 32'h0, 1'b1);
        check("unmapped read", 32'h0, rd);
        $display("test reset done");
    endtask
    // delayed switch through codes 1, 2, 3, 4 and back to 0, readback shows active source
    task automatic t_switch;
        logic [2:0] c;
        int k;
        for (int i = 1; i <= 5; i++)
        begin
            c = 3'(i % 5);
            // divider set whenever the loop may drive the system clock
            apb(1'b1, PCS_OFF_CTRL, {20'h0, 4'h1, 5'h0, c}, 1'b0);
            apb(1'b0, PCS_OFF_CTRL, 32'h0, 1'b0);
            check("src early", {29'h0, 3'(i - 1)}, {29'h0, rd[2:0]});
            apb(1'b0, PCS_OFF_STAT, 32'h0, 1'b0);
            check("stat req", {28'h0, 1'b1, c}, {28'h0, rd[3:0]});
            for (k = 0; k < 300 && active_source !== c; k++)
                @(posedge pclk);
            limit(k, 300);
            apb(1'b0, PCS_OFF_CTRL, 32'h0, 1'b0);
            check("src read", {29'h0, c}, {29'h0, rd[2:0]});
            count_rises(1'b1, k);
            check("sys_clk rises", 32'(rises[c]), 32'(k));
        end
        $display("test switch done");
    endtask
    // reserved codes dropped, other fields still stored
    task automatic t_reserved;
        for (int i = 5; i <= 7; i++)
        begin
            apb(1'b1, PCS_OFF_CTRL, {20'h0, 4'hA, 5'h0, 3'(i)}, 1'b0);
            repeat (40) @(posedge pclk);
            check("src kept", 32'h0, {29'h0, active_source});
            apb(1'b0, PCS_OFF_CTRL, 32'h0, 1'b0);
            check("ctrl read", 32'h0000_0A00, {20'h0, rd[11:0]});
            check("divider", 32'h0000_000A, {28'h0, sys_clk_divider});
        end
        $display("test reserved done");
    endtask
    // output frequency from dividers and reference choice
    task automatic t_freq(input logic s, input logic [5:0] r, input logic [6:0] n,
        input logic [3:0] o);
        int fin, k;
        fin = s ? 4500 : 3000;
        idle_calc();
        apb(1'b1, PCS_OFF_CTRL, {28'h0, s, 3'h0}, 1'b0);
        idle_calc();
        apb(1'b1, PCS_OFF_LOOP, {12'h0, o, 1'b0, n, 2'h0, r}, 1'b0);
        check("loop_cfg", {15'h0, r, n, o}, {15'h0, loop_cfg});
        idle_calc();
        apb(1'b0, PCS_OFF_FREQ, 32'h0, 1'b0);
        check("freq", 32'(fin * (n + 1) / ((r + 1) * (o + 1))), rd);
        count_rises(1'b0, k);
        check("ref rises", s ? 32'h2 : 32'h4, 32'(k));
        $display("test freq done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_switch();
        t_reserved();
        // every setting keeps the loop ranges and a 1.5 MHz or faster reference
        t_freq(1'b0, 6'h00, 7'h1F, 4'h1);
        t_freq(1'b1, 6'h02, 7'h3F, 4'h1);
        t_freq(1'b0, 6'h00, 7'h3F, 4'h4);
        test_done();
    end
endmodule
`default_nettype wire
